// >>> nvtr_pkg.sv
// Shared constants and types for the timekeeping RAM with a clock.
`default_nettype none
package nvtr_pkg;
  localparam int          ADDR_W         = 13;
  localparam int          DATA_W         = 8;
  localparam int          CLK_HZ         = 200_000_000;
  localparam int          TICK_HZ        = 1024;
  localparam int          TICK_CYCLES    = CLK_HZ / TICK_HZ;
  localparam int          TICKS_PER_SEC  = 1024;
  localparam logic [9:0]  CLK_BASE_HI    = 10'h3FF;
  localparam int          CENT_IX        = 0;
  localparam int          SEC_IX         = 1;
  localparam int          MIN_IX         = 2;
  localparam int          HR_IX          = 3;
  localparam int          DAY_IX         = 4;
  localparam int          DATE_IX        = 5;
  localparam int          MON_IX         = 6;
  localparam int          YR_IX          = 7;
  localparam int          WBIT_POS       = 7;
  localparam int          RBIT_POS       = 6;
  localparam int          XTAL_HALT_POS  = 7;
  localparam int          TICK_TEST_POS  = 6;
  localparam logic [7:0]  BCD_SEC_MAX    = 8'h59;
  localparam logic [7:0]  BCD_HR_MAX     = 8'h23;
  localparam logic [7:0]  BCD_DAY_MAX    = 8'h07;
  localparam logic [7:0]  BCD_MON_MAX    = 8'h12;
  localparam logic [7:0]  BCD_YR_MAX     = 8'h99;
  localparam logic [7:0]  BCD_CENT_MAX   = 8'h39;
  localparam logic [7:0]  BCD_ONE        = 8'h01;
  localparam logic [7:0]  BCD_FEB        = 8'h02;
  localparam logic [7:0]  BCD_APR        = 8'h04;
  localparam logic [7:0]  BCD_JUN        = 8'h06;
  localparam logic [7:0]  BCD_SEP        = 8'h09;
  localparam logic [7:0]  BCD_NOV        = 8'h11;
  localparam logic [7:0]  DIM_28         = 8'h28;
  localparam logic [7:0]  DIM_29         = 8'h29;
  localparam logic [7:0]  DIM_30         = 8'h30;
  localparam logic [7:0]  DIM_31         = 8'h31;
  typedef logic [7:0] nvtr_regs_t [8];
  localparam nvtr_regs_t  TIME_MASK      = '{8'h3F, 8'h7F, 8'h7F, 8'h3F,
                                             8'h07, 8'h3F, 8'h1F, 8'hFF};
  localparam nvtr_regs_t  TIME_RST       = '{8'h20, 8'h00, 8'h00, 8'h00,
                                             8'h01, 8'h01, 8'h01, 8'h00};
endpackage
`default_nettype wire

// >>> nvtr_core.sv
// Byte-wide RAM whose top eight locations are a BCD clock and calendar.
//
// Contract
// - 8k by 8 memory; top eight addresses are clock registers.
// - Registers hold century through seconds in BCD, 24-hour hours.
// - Month lengths and leap years handled correctly through year 2100.
// - Internal counters are separate; host access never stalls counting.
// - Power fail indication deselects; reads and writes are ignored.
// - Century bit 6 set halts transfers into visible registers.
// - While halted, visible registers freeze; internal counters advance.
// - After read-halt clears, registers refresh together within a second.
// - Century bit 7 set halts updates; host then loads BCD time.
// - Clearing century bit 7 loads host values into internal counters.
// - Seconds bit 7 stops the oscillator; writable at any time.
// - Day bit 6 with oscillator running toggles seconds LSB at 512 Hz.
// - Sustained seconds read in test mode shows the toggle on line zero.
// - Read when select low, second select high, output drive low and store strobe high.
// - Write when store strobe and select both low and second select high; address held stable.
// - A write begins at the later of the two falling edges.
// - Unassigned clock register bits are ordinary read-write storage.
`timescale 1ns/1ps
`default_nettype none
module nvtr_core
  import nvtr_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int TICK_SEC = TICKS_PER_SEC
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr_lines,
  input  wire logic              chip_sel_n,
  input  wire logic              second_select,
  input  wire logic              out_drive_n,
  input  wire logic              store_n,
  input  wire logic              power_fail,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic      [DATA_W-1:0] data_oe
);
  localparam int SYNC_W = ADDR_W + DATA_W + 5;
  localparam int TC_W   = $clog2(TICK_CYC + 1);
  localparam int TS_W   = $clog2(TICK_SEC + 1);

  logic [SYNC_W-1:0] s1_r, s2_r;
  logic [ADDR_W-1:0] a_s;
  logic [DATA_W-1:0] d_s;
  logic              cs_n_s, sel2_s, oe_n_s, we_n_s, pf_s;
  logic [7:0]        mem [2**ADDR_W];
  nvtr_regs_t        cnt_r, cnt_nxt, vis_r, vis_nxt;
  logic [TC_W-1:0]   tcnt_r, tcnt_nxt;
  logic [TS_W-1:0]   sub_r, sub_nxt;
  logic              ph_r, ph_nxt, wbit_q_r, wr_q_r;
  logic [7:0]        dout_r, dout_nxt;
  logic              oe_r, oe_nxt;
  logic              sel, rd_act, wr_act, clk_hit, hold, wbit, load;
  logic              crystal_halt_bit, test_on, tick, sec_tick, wr_start;
  logic [2:0]        ix;

  function automatic logic [7:0] bcd_inc(input logic [7:0] b);
    return (b[3:0] == 4'h9) ? {b[7:4] + 4'h1, 4'h0} : b + 8'h01;
  endfunction

  function automatic logic bcd_div4(input logic [7:0] b);
    return b[4] ? (b[3:0] == 4'h2 || b[3:0] == 4'h6)
                : (b[3:0] == 4'h0 || b[3:0] == 4'h4 || b[3:0] == 4'h8);
  endfunction

  function automatic logic wrap_inc(input logic [7:0] v,
                                    input logic [7:0] top,
                                    input logic [7:0] low,
                                    output logic [7:0] n);
    n = (v == top) ? low : bcd_inc(v);
    return v == top;
  endfunction

  function automatic nvtr_regs_t nvtr_advance(input nvtr_regs_t c0);
    nvtr_regs_t c;
    nvtr_regs_t n;
    logic       leap;
    logic [7:0] dim;
    logic       cy;
    for (int i = 0; i < 8; i++)
      c[i] = c0[i] & TIME_MASK[i];
    n = c;
    // Year 00 is a leap year only when the century divides by four.
    leap = bcd_div4(c[YR_IX]) && (c[YR_IX] != 8'h00 || bcd_div4(c[CENT_IX]));
    unique case (c[MON_IX])
      BCD_FEB:                         dim = leap ? DIM_29 : DIM_28;
      BCD_APR, BCD_JUN, BCD_SEP, BCD_NOV: dim = DIM_30;
      default:                         dim = DIM_31;
    endcase
    cy = wrap_inc(c[SEC_IX], BCD_SEC_MAX, 8'h00, n[SEC_IX]);
    if (cy)
      cy = wrap_inc(c[MIN_IX], BCD_SEC_MAX, 8'h00, n[MIN_IX]);
    if (cy)
      cy = wrap_inc(c[HR_IX], BCD_HR_MAX, 8'h00, n[HR_IX]);
    if (cy)
    begin
      void'(wrap_inc(c[DAY_IX], BCD_DAY_MAX, BCD_ONE, n[DAY_IX]));
      cy = wrap_inc(c[DATE_IX], dim, BCD_ONE, n[DATE_IX]);
      if (cy)
        cy = wrap_inc(c[MON_IX], BCD_MON_MAX, BCD_ONE, n[MON_IX]);
      if (cy)
        cy = wrap_inc(c[YR_IX], BCD_YR_MAX, 8'h00, n[YR_IX]);
      if (cy)
        void'(wrap_inc(c[CENT_IX], BCD_CENT_MAX, 8'h00, n[CENT_IX]));
    end
    return n;
  endfunction

  // Pins come from an asynchronous host and pass two flops first.
  always_ff @(posedge ref_clk)
  begin
    s1_r <= {addr_lines, data_in, chip_sel_n, second_select, out_drive_n,
             store_n, power_fail};
    s2_r <= s1_r;
  end
  assign {a_s, d_s, cs_n_s, sel2_s, oe_n_s, we_n_s, pf_s} = s2_r;

  assign sel      = !cs_n_s && sel2_s && !pf_s;
  assign rd_act   = sel && !oe_n_s && we_n_s;
  assign wr_act   = sel && !we_n_s;
  assign wr_start = wr_act && !wr_q_r;
  assign clk_hit  = (a_s[ADDR_W-1:3] == CLK_BASE_HI);
  assign ix       = a_s[2:0];
  assign wbit     = vis_r[CENT_IX][WBIT_POS];
  assign hold     = wbit || vis_r[CENT_IX][RBIT_POS];
  assign load     = wbit_q_r && !wbit;
  assign crystal_halt_bit = vis_r[SEC_IX][XTAL_HALT_POS];
  assign test_on  = vis_r[DAY_IX][TICK_TEST_POS] && !crystal_halt_bit;
  assign tick     = !crystal_halt_bit && (tcnt_r == TC_W'(TICK_CYC - 1));
  assign sec_tick = tick && (sub_r == TS_W'(TICK_SEC - 1));

  // Plain storage below the clock block; the clock block never aliases it.
  always_ff @(posedge ref_clk)
  begin
    if (wr_act && !clk_hit)
      mem[a_s] <= d_s;
  end

  always_comb
  begin
    tcnt_nxt = tcnt_r;
    sub_nxt  = sub_r;
    ph_nxt   = ph_r;
    cnt_nxt  = cnt_r;
    vis_nxt  = vis_r;
    if (!crystal_halt_bit)
    begin
      tcnt_nxt = tick ? '0 : tcnt_r + TC_W'(1);
      if (tick)
      begin
        sub_nxt = sec_tick ? '0 : sub_r + TS_W'(1);
        ph_nxt  = !ph_r;
      end
    end
    // Counting never waits on the host or on a read or write halt.
    if (sec_tick)
      cnt_nxt = nvtr_advance(cnt_r);
    for (int i = 0; i < 8; i++)
    begin
      if (load)
        cnt_nxt[i] = vis_r[i] & TIME_MASK[i];
      if (!hold)
        vis_nxt[i] = (vis_r[i] & ~TIME_MASK[i])
                   | (cnt_r[i] & TIME_MASK[i]);
    end
    // Host bytes land whole; spare bits are kept as storage.
    if (wr_act && clk_hit)
      vis_nxt[ix] = d_s;
  end

  always_comb
  begin
    dout_nxt = clk_hit ? vis_r[ix] : mem[a_s];
    if (clk_hit && ix == 3'(SEC_IX) && test_on)
      dout_nxt[0] = ph_r;
    oe_nxt = rd_act;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tcnt_r   <= '0;
      sub_r    <= '0;
      ph_r     <= 1'b0;
      cnt_r    <= TIME_RST;
      vis_r    <= TIME_RST;
      wbit_q_r <= 1'b0;
      wr_q_r   <= 1'b0;
      dout_r   <= 8'h00;
      oe_r     <= 1'b0;
    end
    else
    begin
      tcnt_r   <= tcnt_nxt;
      sub_r    <= sub_nxt;
      ph_r     <= ph_nxt;
      cnt_r    <= cnt_nxt;
      vis_r    <= vis_nxt;
      wbit_q_r <= wbit;
      wr_q_r   <= wr_act;
      dout_r   <= dout_nxt;
      oe_r     <= oe_nxt;
    end
  end

  assign data_out = dout_r;
  assign data_oe  = {DATA_W{oe_r}};

  property p_pf_quiet;
    @(posedge ref_clk) disable iff (!rst_n) pf_s |=> !oe_r;
  endproperty
  a_pf_quiet: assert property (p_pf_quiet)
    else $error("drive in power fail");

  property p_desel;
    @(posedge ref_clk) disable iff (!rst_n) (cs_n_s || !sel2_s) |=> !oe_r;
  endproperty
  a_desel: assert property (p_desel)
    else $error("drive while deselected");

  property p_oe_high;
    @(posedge ref_clk) disable iff (!rst_n) oe_n_s |=> !oe_r;
  endproperty
  a_oe_high: assert property (p_oe_high)
    else $error("drive with oe high");

  property p_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd_act && !clk_hit) |=> oe_r && data_out == mem[$past(a_s)];
  endproperty
  a_read: assert property (p_read)
    else $error("read data wrong");

  property p_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_act && clk_hit && ix == 3'(DAY_IX)) |=> vis_r[DAY_IX] == $past(d_s);
  endproperty
  a_write: assert property (p_write)
    else $error("clock write lost");

  property p_halt_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (hold && !wr_act) ##1 hold |-> vis_r[MIN_IX] == $past(vis_r[MIN_IX]);
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("halted reg moved");

  property p_count_on;
    @(posedge ref_clk) disable iff (!rst_n)
      (sec_tick && hold && !load) |=> cnt_r[SEC_IX] != $past(cnt_r[SEC_IX]);
  endproperty
  a_count_on: assert property (p_count_on)
    else $error("count stalled");

  property p_refresh;
    @(posedge ref_clk) disable iff (!rst_n)
      (!hold && !wr_act) ##1 !wr_act |->
        (vis_r[HR_IX] & TIME_MASK[HR_IX]) == $past(cnt_r[HR_IX])
        && (vis_r[YR_IX] & TIME_MASK[YR_IX]) == $past(cnt_r[YR_IX]);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("no refresh");

  property p_load;
    @(posedge ref_clk) disable iff (!rst_n)
      load |=> cnt_r[MIN_IX] == $past(vis_r[MIN_IX] & TIME_MASK[MIN_IX]);
  endproperty
  a_load: assert property (p_load)
    else $error("load failed");

  property p_crystal_halt;
    @(posedge ref_clk) disable iff (!rst_n)
      (crystal_halt_bit && !load) |=>
        $stable(cnt_r[SEC_IX]) && $stable(tcnt_r);
  endproperty
  a_crystal_halt: assert property (p_crystal_halt)
    else $error("count while stopped");

  property p_tick_toggle;
    @(posedge ref_clk) disable iff (!rst_n) tick |=> ph_r != $past(ph_r);
  endproperty
  a_tick_toggle: assert property (p_tick_toggle)
    else $error("test phase stuck");

  c_wr_start: cover property (@(posedge ref_clk) wr_start && clk_hit);
  c_load:     cover property (@(posedge ref_clk) load);
  c_sec:      cover property (@(posedge ref_clk) sec_tick && hold);
  c_test_read: cover property (@(posedge ref_clk) rd_act && test_on && tick);
endmodule
`default_nettype wire

// >>> nvtr_host.sv
// Host processor model that drives the byte-wide bus of the clock RAM.
`timescale 1ns/1ps
`default_nettype none
module nvtr_host
  import nvtr_pkg::*;
(
  input  wire logic              ref_clk,
  output logic      [ADDR_W-1:0] addr_lines,
  output logic                   chip_sel_n,
  output logic                   second_select,
  output logic                   out_drive_n,
  output logic                   store_n,
  output logic      [DATA_W-1:0] data_in,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic [DATA_W-1:0] data_oe,
  output logic                   rd_valid,
  output logic      [15:0]       rd_word
);
  logic              drv;
  logic [DATA_W-1:0] wd;
  logic [DATA_W-1:0] last_r;

  // A line nobody drives shows the inverse of its last level.
  assign data_in = drv ? wd : (data_oe[0] ? data_out : ~last_r);

  always @(posedge ref_clk) last_r <= data_in;

  initial
  begin
    last_r = 8'h00;
    addr_lines = 13'h0000;
    wd = 8'h00;
    drv = 1'b0;
    {chip_sel_n, second_select, out_drive_n, store_n} = 4'hF;
    rd_valid = 1'b0;
    rd_word = 16'h0000;
  end

  // Control is {select_n, second select, drive_n, store_n}; a plain read
  // of four cycles is reported, longer holds only count toggles on bit 0.
  task automatic bus(input logic [ADDR_W-1:0] a, input logic [3:0] ctl,
                     input logic [DATA_W-1:0] d, input int n,
                     output int tog);
    int   k;
    logic p;
    tog = 0;
    @(posedge ref_clk);
    #1;
    addr_lines = a;
    {chip_sel_n, second_select, out_drive_n, store_n} = ctl;
    wd = d;
    drv = ~ctl[0];
    for (k = 1; k <= n; k++)
    begin
      @(posedge ref_clk);
      #1;
      if (k > 4 && data_out[0] !== p)
        tog++;
      p = data_out[0];
    end
    rd_word = {data_oe, data_out};
    rd_valid = ctl[0] && (n == 4);
    @(posedge ref_clk);
    #1;
    rd_valid = 1'b0;
    {chip_sel_n, second_select, out_drive_n, store_n} = 4'hF;
    drv = 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// >>> nv_timekeeping_ram_clock_access_tb.sv
// Self-checking bench for the byte-wide RAM with clock and calendar.
`timescale 1ns/1ps
`default_nettype none
module nv_timekeeping_ram_clock_access_tb;
  import nvtr_pkg::*;
  logic              ref_clk;
  logic              rst_n;
  logic              power_fail;
  logic [ADDR_W-1:0] addr_lines;
  logic              chip_sel_n;
  logic              second_select;
  logic              out_drive_n;
  logic              store_n;
  logic [DATA_W-1:0] data_in;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] data_oe;
  logic              rd_valid;
  logic [15:0]       rd_word;
  logic [15:0]       exp_q[$];
  logic [ADDR_W-1:0] am[8];
  logic [7:0]        dm[8];
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 32'h36B7;
  int cyc = 0;
  int t;
  // Century, year, month, date, then expected date, month and year.
  logic [7:0] tt[6][7] = '{'{8'h20, 8'h00, 8'h02, 8'h28, 8'h29, 8'h02, 8'h00},
    '{8'h21, 8'h00, 8'h02, 8'h28, 8'h01, 8'h03, 8'h00},
    '{8'h20, 8'h01, 8'h02, 8'h28, 8'h01, 8'h03, 8'h01},
    '{8'h20, 8'h04, 8'h02, 8'h29, 8'h01, 8'h03, 8'h04},
    '{8'h20, 8'h01, 8'h04, 8'h30, 8'h01, 8'h05, 8'h01},
    '{8'h20, 8'h01, 8'h12, 8'h31, 8'h01, 8'h01, 8'h02}};

  nvtr_core #(.TICK_CYC(4), .TICK_SEC(4)) dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .addr_lines(addr_lines), .chip_sel_n(chip_sel_n),
    .second_select(second_select), .out_drive_n(out_drive_n),
    .store_n(store_n), .power_fail(power_fail), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe));

  nvtr_host host (.ref_clk(ref_clk), .addr_lines(addr_lines),
    .chip_sel_n(chip_sel_n), .second_select(second_select),
    .out_drive_n(out_drive_n), .store_n(store_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .rd_valid(rd_valid),
    .rd_word(rd_word));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [ADDR_W-1:0] ca(input int ix);
    return {CLK_BASE_HI, 3'(ix)};
  endfunction

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [3:0] c,
                    input logic [7:0] e);
    exp_q.push_back({{8{c == 4'h5 && !power_fail}}, e});
    host.bus(a, c, 8'h00, 4, t);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                    input logic [3:0] c = 4'h6);
    host.bus(a, c, d, 3, t);
  endtask

  task automatic chk_rd(input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g[15:8] !== e[15:8] || (e[8] && g[7:0] !== e[7:0]))
    begin
      error_cnt++;
      $display("Error at %0t: read gave %h, expected %h", $time, g, e);
    end
  endtask

  task automatic chk_tog(input int g, input int lo, input int hi);
    n_tests++;
    if (g < lo || g > hi)
    begin
      error_cnt++;
      $display("Error at %0t: %0d toggles on line zero", $time, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (rd_valid === 1'b1)
      chk_rd(exp_q.pop_front(), rd_word);
    if (cyc == 12000)
    begin
      error_cnt++;
      $display("Error at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    power_fail = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    rd(ca(CENT_IX), 4'h5, 8'h20);
    rd(ca(DATE_IX), 4'h5, 8'h01);
    rd(ca(DAY_IX), 4'h5, 8'h01);
    wr(ca(MON_IX), 8'hE1);
    rd(ca(MON_IX), 4'h5, 8'hE1);
    wr(ca(DATE_IX), 8'hC1);
    rd(ca(DATE_IX), 4'h5, 8'hC1);
    for (int i = 0; i < 8; i++)
    begin
      am[i] = 13'(i * 32'h400 + $unsigned($random(seed)) % 32'h3F8);
      am[i] = (i == 7) ? 13'h1FF7 : am[i];
      dm[i] = 8'($random(seed));
      wr(am[i], dm[i]);
    end
    foreach (am[i])
      rd(am[i], 4'h5, dm[i]);
    wr(13'h0123, 8'h5A);
    for (int m = 0; m < 3; m++)
    begin
      #1;
      power_fail = (m == 2);
      wr(13'h0123, 8'hA5, (m == 0) ? 4'hE : (m == 1) ? 4'h2 : 4'h6);
      rd(13'h0123, (m == 0) ? 4'hD : (m == 1) ? 4'h1 : 4'h5, 8'h00);
      #1;
      power_fail = 1'b0;
      rd(13'h0123, 4'h5, 8'h5A);
    end
    rd(13'h0123, 4'h7, 8'h00);
    foreach (tt[r])
    begin
      wr(ca(CENT_IX), tt[r][0] | 8'h80);
      wr(ca(YR_IX), tt[r][1]);
      wr(ca(MON_IX), tt[r][2]);
      wr(ca(DATE_IX), tt[r][3]);
      wr(ca(DAY_IX), 8'h01);
      wr(ca(HR_IX), 8'h23);
      wr(ca(MIN_IX), 8'h59);
      wr(ca(SEC_IX), 8'hD9);
      wr(ca(CENT_IX), tt[r][0]);
      repeat (40) @(posedge ref_clk);
      rd(ca(SEC_IX), 4'h5, 8'hD9);
      wr(ca(CENT_IX), tt[r][0] | 8'h40);
      wr(ca(SEC_IX), 8'h59);
      repeat (40) @(posedge ref_clk);
      rd(ca(SEC_IX), 4'h5, 8'h59);
      wr(ca(CENT_IX), tt[r][0]);
      repeat (8) @(posedge ref_clk);
      rd(ca(HR_IX), 4'h5, 8'h00);
      rd(ca(MIN_IX), 4'h5, 8'h00);
      rd(ca(DATE_IX), 4'h5, tt[r][4]);
      rd(ca(MON_IX), 4'h5, tt[r][5]);
      rd(ca(YR_IX), 4'h5, tt[r][6]);
      rd(ca(DAY_IX), 4'h5, 8'h02);
    end
    wr(ca(SEC_IX), 8'h80);
    wr(ca(DAY_IX), 8'h41);
    host.bus(ca(SEC_IX), 4'h5, 8'h00, 28, t);
    chk_tog(t, 0, 0);
    wr(ca(SEC_IX), 8'h00);
    host.bus(ca(SEC_IX), 4'h5, 8'h00, 28, t);
    chk_tog(t, 5, 7);
    repeat (5) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
